// ==== design/sesu_pkg.sv ====
// constants for the status, exception and strobe unit
// assumes one core clock and an spi serial clock from the host
//
// Operation
// - status byte leaves on so during the byte after the opcode
// - status captured at byte edges, msb first
// - no-operation returns status, changes nothing
// - bits 7,6: oscillator stable, rssi valid
// - bits 5,4: masked flags channel a/b
// - bits 3,2: high/low priority processing busy
// - bits 1,0: transmit mode, receive mode
// - one-byte opcodes are strobes except two
// - oscillator start only straight from spi
// - gpio edge per polarity fires its strobe
// - bindings x and y map exception to strobe
// - load stores strobe, execute runs it
// - executed buffer reverts to no-operation
// - execute with load: old runs, new lost
// - flags readable and visible outside
// - writing zero clears flag, one keeps
// - set in same cycle beats clear
// - exception number equals flag bit index
// - idle entry, transmit done, abort suppression
// - transmit underflow and overflow flagged
// - receive underflow and overflow flagged
// - lookup done only with lookup enabled, hit just before
// - chip select rising mid-byte raises 0x13
package sesu_pkg;
    localparam int EXC_COUNT = 24;
    localparam int EXC_IDX_W = 5;
    // exception numbers are flag bit indices
    localparam int EXC_RADIO_IDLE = 32'h00;
    localparam int EXC_TX_FRAME = 32'h01;
    localparam int EXC_TX_ACK = 32'h02;
    localparam int EXC_LOOKUP_DONE = 32'h0a;
    localparam int EXC_LOOKUP_HIT = 32'h0b;
    localparam int EXC_SPI_ABORT = 32'h13;
    // status byte positions
    localparam int ST_OSC = 7;
    localparam int ST_RSSI = 6;
    localparam int ST_CHAN_A = 5;
    localparam int ST_CHAN_B = 4;
    localparam int ST_DPU_H = 3;
    localparam int ST_DPU_L = 2;
    localparam int ST_TX = 1;
    localparam int ST_RX = 0;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] BIT_FIRST = 3'h0;
    // opcode values, plain defaults
    localparam logic [7:0] NO_OPERATION_INSTR = 8'h00;
    localparam logic [7:0] STROBE_BUFFER_LOAD_INSTR = 8'h02;
    localparam logic [7:0] STROBE_LO = 8'h40;
    localparam logic [7:0] STROBE_HI = 8'h4f;
    localparam logic [7:0] OSCILLATOR_START_INSTR = 8'h40;
    localparam logic [7:0] STROBE_BUFFER_EXECUTE = 8'h41;
    localparam logic [7:0] RECEIVE_ON_STROBE = 8'h42;
    localparam logic [7:0] TRANSMIT_ON_STROBE = 8'h43;
    localparam logic [7:0] RADIO_OFF_STROBE = 8'h45;
    typedef enum logic {SESU_OPCODE, SESU_OPERAND} sesu_parse_t;
endpackage

// ==== design/sesu_top.sv ====
// status byte, exception flags and strobe dispatch
// assumes spi mode 0 host; event inputs are core-clock pulses
`timescale 1ns/100ps
`default_nettype none
module sesu_top import sesu_pkg::*; #(
    parameter int NUM_GPIO = 6
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic sclk,
    input wire logic csn,
    input wire logic si,
    output logic so,
    output logic so_oe,
    input wire logic crystal_oscillator_stable,
    input wire logic rssi_valid,
    input wire logic dpu_high_busy,
    input wire logic dpu_low_busy,
    input wire logic tx_active,
    input wire logic rx_active,
    input wire logic [EXC_COUNT-1:0] channel_a_mask,
    input wire logic [EXC_COUNT-1:0] channel_b_mask,
    input wire logic [EXC_COUNT-1:0] exc_event,
    input wire logic radio_idle,
    input wire logic source_lookup_enable,
    input wire logic flag_write,
    input wire logic [EXC_COUNT-1:0] flag_write_data,
    output logic [EXC_COUNT-1:0] exception_flag_regs,
    output logic exc_channel_a,
    output logic exc_channel_b,
    input wire logic [NUM_GPIO-1:0] gpio_pin,
    input wire logic [NUM_GPIO-1:0] gpio_trigger_en,
    input wire logic [NUM_GPIO-1:0] pin_edge_polarity,
    input wire logic [NUM_GPIO*8-1:0] gpio_strobe_codes,
    input wire logic bind_x_enable,
    input wire logic [EXC_IDX_W-1:0] bind_x_exception,
    input wire logic [7:0] bind_x_strobe,
    input wire logic bind_y_enable,
    input wire logic [EXC_IDX_W-1:0] bind_y_exception,
    input wire logic [7:0] bind_y_strobe,
    output logic strobe_valid,
    output logic [7:0] strobe_code,
    output logic osc_start_pulse
);
    if (NUM_GPIO < 1 || NUM_GPIO > 8) begin : g_chk
        $error("sesu_top: NUM_GPIO must be 1 to 8");
    end

    function automatic logic is_strobe(input logic [7:0] code);
        is_strobe = code >= STROBE_LO && code <= STROBE_HI
            && code != OSCILLATOR_START_INSTR;
    endfunction

    // ==========================================================
    // spi side, on the serial clock
    // ==========================================================
    logic [7:0] status_word;
    logic [2:0] bit_cnt;
    logic in_first;
    logic mid_byte;
    logic [6:0] shift_in;
    // power-up values: this domain has no reset of its own
    logic [7:0] rx_byte = 8'h00;
    logic rx_first = 1'b0;
    logic rx_toggle = 1'b0;
    logic [6:0] shift_out = 7'h00;
    logic [7:0] st_s1 = 8'h00;
    logic [7:0] st_s2 = 8'h00;

    // chip select high holds the byte counter at rest
    always_ff @(posedge sclk or posedge csn) begin
        if (csn) begin
            bit_cnt <= BIT_FIRST;
            in_first <= 1'b1;
            mid_byte <= 1'b0;
        end else begin
            bit_cnt <= bit_cnt + 3'h1;
            shift_in <= {shift_in[5:0], si};
            mid_byte <= bit_cnt != BIT_LAST;
            if (bit_cnt == BIT_LAST) begin
                in_first <= 1'b0;
            end
        end
    end

    // finished byte handed over by toggle, held stable for a byte
    always_ff @(posedge sclk) begin
        if (!csn && bit_cnt == BIT_LAST) begin
            rx_byte <= {shift_in, si};
            rx_first <= in_first;
            rx_toggle <= ~rx_toggle;
        end
    end

    // status word from the core only changes between bytes
    always_ff @(negedge sclk) begin
        st_s1 <= status_word;
        st_s2 <= st_s1;
    end

    // last falling edge of a byte captures a fresh status
    always_ff @(negedge sclk) begin
        if (bit_cnt == BIT_FIRST && !in_first) begin
            so <= st_s2[7];
            shift_out <= st_s2[6:0];
        end else begin
            so <= shift_out[6];
            shift_out <= {shift_out[5:0], 1'b0};
        end
    end

    // ==========================================================
    // crossings into the core clock
    // ==========================================================
    logic csn_s1, csn_s2, csn_s3;
    logic mb_s1, mb_s2, mb_d;
    logic tog_s1, tog_s2, tog_s3;
    logic [NUM_GPIO-1:0] gp_s1, gp_s2, gp_s3;

    always_ff @(posedge clock) begin
        if (rst) begin
            csn_s1 <= 1'b1;
            csn_s2 <= 1'b1;
            csn_s3 <= 1'b1;
            mb_s1 <= 1'b0;
            mb_s2 <= 1'b0;
            mb_d <= 1'b0;
            tog_s1 <= 1'b0;
            tog_s2 <= 1'b0;
            tog_s3 <= 1'b0;
        end else begin
            csn_s1 <= csn;
            csn_s2 <= csn_s1;
            csn_s3 <= csn_s2;
            mb_s1 <= mid_byte;
            mb_s2 <= mb_s1;
            mb_d <= mb_s2;
            tog_s1 <= rx_toggle;
            tog_s2 <= tog_s1;
            tog_s3 <= tog_s2;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            gp_s1 <= '0;
            gp_s2 <= '0;
            gp_s3 <= '0;
        end else begin
            gp_s1 <= gpio_pin;
            gp_s2 <= gp_s1;
            gp_s3 <= gp_s2;
        end
    end

    // ==========================================================
    // instruction decode and strobe sources
    // ==========================================================
    sesu_parse_t parse;
    logic byte_evt, spi_strobe, spi_osc, load_now;
    logic [NUM_GPIO-1:0] gp_hit;
    logic gp_any;
    logic [7:0] gp_code;
    logic [EXC_COUNT-1:0] evt_q;
    logic bx_hit, by_hit;
    logic req_valid, req_exec;
    logic [7:0] req_code;
    logic [7:0] sbuf;
    logic next_valid;
    logic [7:0] next_code;

    assign byte_evt = tog_s2 ^ tog_s3;
    assign spi_strobe = byte_evt && rx_first && is_strobe(rx_byte);
    assign spi_osc = byte_evt && rx_first && rx_byte == OSCILLATOR_START_INSTR;
    assign load_now = byte_evt && !rx_first && parse == SESU_OPERAND;

    always_ff @(posedge clock) begin
        if (rst) begin
            parse <= SESU_OPCODE;
        end else if (byte_evt) begin
            unique case (parse)
                SESU_OPCODE: begin
                    if (rx_first && rx_byte == STROBE_BUFFER_LOAD_INSTR) begin
                        parse <= SESU_OPERAND;
                    end
                end
                SESU_OPERAND: begin
                    parse <= SESU_OPCODE;
                end
            endcase
        end else if (csn_s2) begin
            parse <= SESU_OPCODE;
        end
    end

    // polarity high selects the rising edge
    assign gp_hit = gpio_trigger_en
        & ((pin_edge_polarity & gp_s2 & ~gp_s3)
        | (~pin_edge_polarity & ~gp_s2 & gp_s3));

    // lowest pin wins when several fire together
    always_comb begin
        gp_any = 1'b0;
        gp_code = 8'h00;
        for (int i = NUM_GPIO - 1; i >= 0; i--) begin
            if (gp_hit[i]) begin
                gp_any = 1'b1;
                gp_code = gpio_strobe_codes[i*8 +: 8];
            end
        end
    end

    // bindings look at last cycle's events to avoid a loop
    assign bx_hit = bind_x_enable && evt_q[bind_x_exception];
    assign by_hit = bind_y_enable && evt_q[bind_y_exception];

    // one strobe per cycle: spi, gpio, x, y in that order
    always_comb begin
        req_valid = 1'b1;
        req_code = bind_y_strobe;
        if (spi_strobe) begin
            req_code = rx_byte;
        end else if (gp_any) begin
            req_code = gp_code;
        end else if (bx_hit) begin
            req_code = bind_x_strobe;
        end else if (!by_hit) begin
            req_valid = 1'b0;
        end
    end

    assign req_exec = req_valid && req_code == STROBE_BUFFER_EXECUTE;

    // buffered oscillator start is never run
    always_comb begin
        next_valid = req_valid;
        next_code = req_code;
        if (req_exec) begin
            next_code = sbuf;
            next_valid = is_strobe(sbuf) && sbuf != STROBE_BUFFER_EXECUTE;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            sbuf <= NO_OPERATION_INSTR;
        end else if (req_exec) begin
            sbuf <= NO_OPERATION_INSTR;
        end else if (load_now) begin
            sbuf <= rx_byte;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            strobe_valid <= 1'b0;
            strobe_code <= NO_OPERATION_INSTR;
            osc_start_pulse <= 1'b0;
        end else begin
            strobe_valid <= next_valid;
            strobe_code <= next_valid ? next_code : NO_OPERATION_INSTR;
            osc_start_pulse <= spi_osc;
        end
    end

    // ==========================================================
    // exception flags
    // ==========================================================
    logic idle_prev;
    logic tx_abort, spi_abort;
    logic [EXC_COUNT-1:0] new_events, clear_bits, flags;

    // starts high so idle reached by reset raises nothing
    always_ff @(posedge clock) begin
        if (rst) begin
            idle_prev <= 1'b1;
        end else begin
            idle_prev <= radio_idle;
        end
    end

    assign tx_abort = next_valid && (next_code == RADIO_OFF_STROBE
        || next_code == RECEIVE_ON_STROBE || next_code == TRANSMIT_ON_STROBE);
    assign spi_abort = csn_s2 && !csn_s3 && (mb_s2 || mb_d);

    always_comb begin
        new_events = exc_event;
        new_events[EXC_RADIO_IDLE] = radio_idle && !idle_prev;
        new_events[EXC_TX_FRAME] = exc_event[EXC_TX_FRAME] && !tx_abort;
        new_events[EXC_TX_ACK] = exc_event[EXC_TX_ACK] && !tx_abort;
        new_events[EXC_LOOKUP_DONE] = exc_event[EXC_LOOKUP_DONE]
            && source_lookup_enable;
        new_events[EXC_LOOKUP_HIT] = exc_event[EXC_LOOKUP_HIT]
            && source_lookup_enable;
        new_events[EXC_SPI_ABORT] = spi_abort;
    end

    assign clear_bits = flag_write ? ~flag_write_data : '0;
    assign exception_flag_regs = flags;

    always_ff @(posedge clock) begin
        if (rst) begin
            flags <= '0;
        end else begin
            flags <= (flags & ~clear_bits) | new_events;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            evt_q <= '0;
        end else begin
            evt_q <= new_events;
        end
    end

    // ==========================================================
    // status byte and channels
    // ==========================================================
    logic chan_a, chan_b;

    assign chan_a = |(flags & channel_a_mask);
    assign chan_b = |(flags & channel_b_mask);

    always_ff @(posedge clock) begin
        if (rst) begin
            exc_channel_a <= 1'b0;
            exc_channel_b <= 1'b0;
            so_oe <= 1'b0;
        end else begin
            exc_channel_a <= chan_a;
            exc_channel_b <= chan_b;
            so_oe <= !csn_s2;
        end
    end

    // held still inside a byte so the serial side reads a whole word
    always_ff @(posedge clock) begin
        if (rst) begin
            status_word <= 8'h00;
        end else if (csn_s2 || byte_evt) begin
            status_word[ST_OSC] <= crystal_oscillator_stable;
            status_word[ST_RSSI] <= rssi_valid;
            status_word[ST_CHAN_A] <= chan_a;
            status_word[ST_CHAN_B] <= chan_b;
            status_word[ST_DPU_H] <= dpu_high_busy;
            status_word[ST_DPU_L] <= dpu_low_busy;
            status_word[ST_TX] <= tx_active;
            status_word[ST_RX] <= rx_active;
        end
    end

    // ==========================================================
    // checks
    // ==========================================================
    flag_sticky_a: assert property (@(posedge clock) disable iff (rst)
        1'b1 |=> ((flags & $past(flags & ~clear_bits))
        == $past(flags & ~clear_bits)))
        else $error("flag dropped without a clear");

    set_wins_a: assert property (@(posedge clock) disable iff (rst)
        |new_events |=> ((flags & $past(new_events)) == $past(new_events)))
        else $error("new event lost against clear");

    clear_zero_a: assert property (@(posedge clock) disable iff (rst)
        flag_write |=> ((flags & $past(~flag_write_data & ~new_events)) == '0))
        else $error("zero write did not clear flag");

    chan_status_a: assert property (@(posedge clock) disable iff (rst)
        byte_evt ##1 !byte_evt && !csn_s2 |->
        status_word[ST_CHAN_A] == $past(|(flags & channel_a_mask)))
        else $error("channel a status bit wrong");

    buf_revert_a: assert property (@(posedge clock) disable iff (rst)
        req_exec |=> sbuf == NO_OPERATION_INSTR)
        else $error("buffer not reverted after execute");

    load_collide_a: assert property (@(posedge clock) disable iff (rst)
        req_exec && load_now |=> strobe_code == $past(sbuf) || !strobe_valid)
        else $error("new load ran instead of old strobe");

    osc_buffered_a: assert property (@(posedge clock) disable iff (rst)
        strobe_valid |-> strobe_code != OSCILLATOR_START_INSTR)
        else $error("oscillator start dispatched as strobe");

    nop_quiet_a: assert property (@(posedge clock) disable iff (rst)
        byte_evt && rx_first && rx_byte == NO_OPERATION_INSTR |=>
        parse == SESU_OPCODE && !osc_start_pulse)
        else $error("no-operation changed state");

    reset_idle_a: assert property (@(posedge clock)
        rst |=> !new_events[EXC_RADIO_IDLE])
        else $error("idle after reset raised exception");

    spi_abort_a: assert property (@(posedge clock) disable iff (rst)
        spi_abort |=> flags[EXC_SPI_ABORT])
        else $error("mid-byte deselect not flagged");
endmodule // sesu_top
`default_nettype wire

// ==== tb/sesu_spi_host.sv ====
// spi host model: mode 0 master with a 30 ns serial clock
// assumes the device samples si on rising sclk and shifts so on falling sclk
`timescale 1ns/100ps
`default_nettype none
module sesu_spi_host (
    output logic sclk,
    output logic csn,
    output logic si,
    input wire logic so
);
    // ============================================================
    // frame control
    // sclk stands still low outside frames, as a real host does
    initial begin
        sclk = 1'b0;
        csn = 1'b1;
        si = 1'b0;
    end
    task automatic select();
        csn = 1'b0;
        #15;
    endtask
    // ends on a byte boundary unless shift was cut short on purpose
    task automatic deselect();
        #15;
        csn = 1'b1;
        si = ~si;
        #60;
    endtask
    // ============================================================
    // byte transfer
    // fewer than 8 bits breaks the byte, used only to provoke an abort
    task automatic shift(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - nbits; i--) begin
            si = tx[i];
            #15 sclk = 1'b1;
            rx[i] = so;
            #15 sclk = 1'b0;
        end
    endtask
endmodule // sesu_spi_host
`default_nettype wire

// ==== tb/tb.sv ====
// testbench of the status, exception and strobe unit
// assumes the spi host model; core clock 125 mhz, serial clock 30 ns
`timescale 1ns/100ps
`default_nettype none
module tb import sesu_pkg::*;;
    logic clock, rst, sclk, csn, si, so, so_oe, radio_idle, lookup_en, flag_write;
    logic chan_a, chan_b, bx_en, by_en, strobe_valid, osc_pulse;
    logic [7:0] stat, strobe_code, bx_str, by_str, r;
    logic [EXC_COUNT-1:0] mask_a, mask_b, exc_event, flag_wdata, flags;
    logic [5:0] gpio_pin, gpio_en, gpio_pol;
    logic [47:0] gpio_codes;
    logic [4:0] bx_exc, by_exc;
    logic [7:0] strb_q[$];
    int osc_n, num_errors, num_checks, cycles;

    sesu_spi_host host (.sclk(sclk), .csn(csn), .si(si), .so(so));
    sesu_top #(.NUM_GPIO(6)) dut (
        .clock(clock), .rst(rst), .sclk(sclk), .csn(csn), .si(si), .so(so), .so_oe(so_oe),
        .crystal_oscillator_stable(stat[7]), .rssi_valid(stat[6]), .dpu_high_busy(stat[3]),
        .dpu_low_busy(stat[2]), .tx_active(stat[1]), .rx_active(stat[0]),
        .channel_a_mask(mask_a), .channel_b_mask(mask_b), .exc_event(exc_event),
        .radio_idle(radio_idle), .source_lookup_enable(lookup_en), .flag_write(flag_write),
        .flag_write_data(flag_wdata), .exception_flag_regs(flags), .exc_channel_a(chan_a),
        .exc_channel_b(chan_b), .gpio_pin(gpio_pin), .gpio_trigger_en(gpio_en),
        .pin_edge_polarity(gpio_pol), .gpio_strobe_codes(gpio_codes),
        .bind_x_enable(bx_en), .bind_x_exception(bx_exc), .bind_x_strobe(bx_str),
        .bind_y_enable(by_en), .bind_y_exception(by_exc), .bind_y_strobe(by_str),
        .strobe_valid(strobe_valid), .strobe_code(strobe_code), .osc_start_pulse(osc_pulse)
    );

    // ============================================================
    // clock, monitor and hang guard
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // strobes are one-cycle pulses, so they are queued at the edge they stand
    always @(posedge clock) begin
        if (strobe_valid === 1'b1) strb_q.push_back(strobe_code);
        if (osc_pulse === 1'b1) osc_n++;
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            wrap_up();
        end
    end

    // ============================================================
    // shared tasks
    task automatic wrap_up();
        $display("checks %0d, errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask
    task automatic exp_strobe(input logic [7:0] exp);
        logic [7:0] v;
        v = 8'hxx;
        for (int i = 0; i < 40 && strb_q.size() == 0; i++) tick(1);
        if (strb_q.size() > 0) v = strb_q.pop_front();
        check("strobe_code", v, exp);
    endtask
    task automatic no_strobe();
        tick(40);
        check("strobe count", strb_q.size(), 0);
        strb_q.delete();
    endtask
    task automatic spi2(input logic [7:0] a, input logic [7:0] b, input int n);
        host.select();
        host.shift(a, 8, r);
        if (n > 1) host.shift(b, 8, r);
        host.deselect();
        tick(1);
    endtask
    task automatic pulse(input int i);
        exc_event[i] = 1'b1;
        tick(1);
        exc_event = '0;
        tick(1);
    endtask
    // writing zeros clears every flag
    task automatic clr_all();
        flag_write = 1'b1;
        flag_wdata = '0;
        tick(1);
        flag_write = 1'b0;
        tick(2);
    endtask

    // ============================================================
    // main sequence
    initial begin
        rst = 1'b1;
        stat = 8'h00;
        {mask_a, mask_b, exc_event, flag_wdata} = '0;
        {lookup_en, flag_write, bx_en, by_en} = '0;
        radio_idle = 1'b1;
        gpio_pin = 6'h02;
        gpio_en = 6'h03;
        gpio_pol = 6'h01;
        gpio_codes = {32'h0, TRANSMIT_ON_STROBE, STROBE_BUFFER_EXECUTE};
        {bx_exc, bx_str, by_exc, by_str} = {5'h04, RECEIVE_ON_STROBE, 5'h06, RADIO_OFF_STROBE};
        tick(4);
        rst = 1'b0;
        tick(4);
        check("flags", flags, 0);
        check("so_oe", so_oe, 0);
        // status byte: second byte returns the capture at the end of the first
        for (int k = 0; k < 2; k++) begin
            stat = k ? 8'h05 : 8'hca;
            tick(4);
            spi2(NO_OPERATION_INSTR, NO_OPERATION_INSTR, 2);
            check("status", r, stat);
        end
        host.select();
        tick(4);
        check("so_oe", so_oe, 1);
        host.shift(NO_OPERATION_INSTR, 8, r);
        host.deselect();
        no_strobe();
        // strobes straight from spi
        spi2(TRANSMIT_ON_STROBE, 8'h00, 1);
        exp_strobe(TRANSMIT_ON_STROBE);
        spi2(OSCILLATOR_START_INSTR, 8'h00, 1);
        no_strobe();
        check("osc starts", osc_n, 1);
        // a buffered oscillator start must never run
        spi2(STROBE_BUFFER_LOAD_INSTR, OSCILLATOR_START_INSTR, 2);
        spi2(STROBE_BUFFER_EXECUTE, 8'h00, 1);
        no_strobe();
        check("osc starts", osc_n, 1);
        // buffer executed from a gpio edge, then left empty
        spi2(STROBE_BUFFER_LOAD_INSTR, RADIO_OFF_STROBE, 2);
        gpio_pin[0] = 1'b1;
        exp_strobe(RADIO_OFF_STROBE);
        spi2(STROBE_BUFFER_EXECUTE, 8'h00, 1);
        no_strobe();
        gpio_pin[1] = 1'b0;
        exp_strobe(TRANSMIT_ON_STROBE);
        gpio_pin[1] = 1'b1;
        no_strobe();
        // exception bindings
        {bx_en, by_en} = 2'b11;
        pulse(4);
        exp_strobe(RECEIVE_ON_STROBE);
        pulse(6);
        exp_strobe(RADIO_OFF_STROBE);
        // execute held on through a load: stored strobe runs, new one is lost
        spi2(STROBE_BUFFER_LOAD_INSTR, RADIO_OFF_STROBE, 2);
        bx_str = STROBE_BUFFER_EXECUTE;
        exc_event[4] = 1'b1;
        exp_strobe(RADIO_OFF_STROBE);
        spi2(STROBE_BUFFER_LOAD_INSTR, TRANSMIT_ON_STROBE, 2);
        exc_event = '0;
        no_strobe();
        spi2(STROBE_BUFFER_EXECUTE, 8'h00, 1);
        no_strobe();
        bx_str = RECEIVE_ON_STROBE;
        {bx_en, by_en} = 2'b00;
        clr_all();
        // sticky flags, masks and clearing
        mask_a = 24'h000010;
        mask_b = 24'h000040;
        pulse(4);
        tick(3);
        check("flags", flags, 24'h000010);
        check("channel a", chan_a, 1);
        check("channel b", chan_b, 0);
        flag_write = 1'b1;
        flag_wdata = '1;
        tick(1);
        flag_write = 1'b0;
        tick(2);
        check("flags", flags, 24'h000010);
        spi2(NO_OPERATION_INSTR, NO_OPERATION_INSTR, 2);
        check("status", r, 8'h25);
        exc_event[4] = 1'b1;
        flag_write = 1'b1;
        flag_wdata = '0;
        tick(1);
        {exc_event, flag_write} = '0;
        tick(1);
        check("flags", flags, 24'h000010);
        clr_all();
        check("flags", flags, 0);
        check("channel a", chan_a, 0);
        // every exception but 0x00 and 0x13 lands on its own bit
        lookup_en = 1'b1;
        for (int i = 1; i < EXC_COUNT; i++) begin
            if (i != EXC_SPI_ABORT) begin
                pulse(i);
                check("flags", flags, 32'h1 << i);
                clr_all();
            end
        end
        lookup_en = 1'b0;
        pulse(EXC_LOOKUP_DONE);
        check("flags", flags, 0);
        // idle entry after leaving idle
        radio_idle = 1'b0;
        tick(2);
        radio_idle = 1'b1;
        tick(3);
        check("flags", flags, 24'h000001);
        clr_all();
        // chip select raised in mid-byte
        host.select();
        host.shift(TRANSMIT_ON_STROBE, 3, r);
        host.deselect();
        tick(10);
        check("flags", flags, 32'h1 << EXC_SPI_ABORT);
        no_strobe();
        wrap_up();
    end
endmodule // tb
`default_nettype wire
